// File: design/pce_clock_enable.sv
// Clock sources, channel join, polarity and enable front end of the PWM unit
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Upper join: ch2 high, ch3 low byte; ch2 pin, ch3 clock; ch3 pin free.
// - Lower join: ch0 high, ch1 low byte; ch0 pin, ch1 clock; ch1 pin free.
// - 3-bit field divides P by two to the field; A for ch0/1, B for ch2/3.
// - Channels 2/3: select 0 picks clock B, 1 picks scaled clock one.
// - Channels 0/1: select 0 picks clock A, 1 picks scaled clock zero.
// - Left-aligned polarity 0 starts low, 1 starts high; duty match flips it.
// - Polarity bits act only in left-aligned mode.
// - Duty counts low time at polarity 0, high time at polarity 1.
// - Enable forces pin output; direction bit kept, rules when cleared.
// - Enable gates the selected clock into the channel.
// - All channels disabled stops the prescaler counter.
// - Clock gating changes only at a clock edge.
// - Waveform appears when the selected clock begins its next cycle.
// - Free 7-bit prescaler counter; readable, writable only in special mode.
// - Scale zero write reloads its counter unless load disable is set.
// - Scaled clock zero is clock A over (value+1), then halved.
// - Scale counter counts down, reloads at zero, readable always.
// - Scaled clock one is clock B over (value+1), then halved.
// - Load disable blocks reload on writes to either scale value.
// - Center-aligned counters count up and down; polarity does not govern.
module pce_clock_enable (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_special_mode_flag,
  input wire logic [3:0] i_port_direction_bits,
  input wire logic [3:0] i_channel_wave,
  output logic [7:0] o_rdata,
  output logic [3:0] o_channel_tick,
  output logic [3:0] o_channel_run,
  output logic [3:0] o_output_polarity,
  output logic [3:0] o_pin_data,
  output logic [3:0] o_pin_oe,
  output logic [3:0] o_pwm_owns_pin,
  output logic o_join_upper_pair,
  output logic o_join_lower_pair,
  output logic o_center_align_select
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire logic rstn;
  assign rstn = rst_sync_reg;

  // ------------------------------------------------------------
  // Special-mode strap synchroniser
  // ------------------------------------------------------------
  logic special_mode_flag_meta_reg;
  logic special_mode_flag_reg;
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      special_mode_flag_meta_reg <= 1'b0;
      special_mode_flag_reg <= 1'b0;
    end else if (i_ce) begin
      special_mode_flag_meta_reg <= i_special_mode_flag;
      special_mode_flag_reg <= special_mode_flag_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  logic [7:0] clock_prescale_and_join_reg;
  logic [7:0] clock_select_and_polarity_reg;
  logic [3:0] channel_enable_reg;
  logic [7:0] scale_value_zero_reg;
  logic [7:0] scale_value_one_reg;
  logic center_align_reg;
  logic scaler_load_disable_reg;
  logic wr_scale0;
  logic wr_scale1;
  logic load_block;
  assign wr_scale0 = i_wr && (i_addr == pce_pkg::ADDR_SCALE_VALUE_ZERO);
  assign wr_scale1 = i_wr && (i_addr == pce_pkg::ADDR_SCALE_VALUE_ONE);
  assign load_block = special_mode_flag_reg && scaler_load_disable_reg;

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      clock_prescale_and_join_reg <= pce_pkg::RESET_BYTE;
      clock_select_and_polarity_reg <= pce_pkg::RESET_BYTE;
      channel_enable_reg <= pce_pkg::RESET_BYTE[3:0];
      scale_value_zero_reg <= pce_pkg::RESET_BYTE;
      scale_value_one_reg <= pce_pkg::RESET_BYTE;
      center_align_reg <= 1'b0;
    end else if (i_ce && i_wr) begin
      if (i_addr == pce_pkg::ADDR_CLOCK_PRESCALE_AND_JOIN) begin
        clock_prescale_and_join_reg <= i_wdata;
      end else if (i_addr == pce_pkg::ADDR_CLOCK_SELECT_AND_POLARITY) begin
        clock_select_and_polarity_reg <= i_wdata;
      end else if (i_addr == pce_pkg::ADDR_CHANNEL_ENABLE) begin
        channel_enable_reg <= i_wdata[3:0];
      end else if (i_addr == pce_pkg::ADDR_SCALE_VALUE_ZERO) begin
        scale_value_zero_reg <= i_wdata;
      end else if (i_addr == pce_pkg::ADDR_SCALE_VALUE_ONE) begin
        scale_value_one_reg <= i_wdata;
      end else if (i_addr == pce_pkg::ADDR_SPECIAL_CONTROL) begin
        center_align_reg <= i_wdata[pce_pkg::BIT_CENTER_ALIGN];
      end
    end
  end

  // Load-disable bit exists only in special mode; cleared in normal mode
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      scaler_load_disable_reg <= 1'b0;
    end else if (i_ce) begin
      if (!special_mode_flag_reg) begin
        scaler_load_disable_reg <= 1'b0;
      end else if (i_wr && i_addr == pce_pkg::ADDR_SPECIAL_CONTROL) begin
        scaler_load_disable_reg <= i_wdata[pce_pkg::BIT_SCALER_LOAD_DISABLE];
      end
    end
  end

  // ------------------------------------------------------------
  // Prescaler and clocks A / B
  // ------------------------------------------------------------
  logic [6:0] prescale_reg;
  logic [6:0] prescale_next;
  logic any_enabled;
  assign any_enabled = |channel_enable_reg;
  assign prescale_next = prescale_reg + 7'h01;

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= 7'h00;
    end else if (i_ce) begin
      if (special_mode_flag_reg && i_wr && i_addr == pce_pkg::ADDR_PRESCALE_COUNTER) begin
        prescale_reg <= i_wdata[6:0];
      end else if (any_enabled) begin
        prescale_reg <= prescale_next;
      end
    end
  end

  // Tap k ticks when the low k bits roll over: one P cycle in 2**k
  logic [7:0] tap_tick;
  assign tap_tick[0] = any_enabled;
  genvar gk;
  generate
    for (gk = 1; gk < 8; gk++) begin : g_tap
      assign tap_tick[gk] = any_enabled && (&prescale_reg[gk-1:0]);
    end
  endgenerate

  logic [2:0] div_a;
  logic [2:0] div_b;
  logic tick_a;
  logic tick_b;
  assign div_a = clock_prescale_and_join_reg[pce_pkg::FLD_CLK_A_HI:
                                             pce_pkg::FLD_CLK_A_LO];
  assign div_b = clock_prescale_and_join_reg[pce_pkg::FLD_CLK_B_HI:
                                             pce_pkg::FLD_CLK_B_LO];
  assign tick_a = tap_tick[div_a];
  assign tick_b = tap_tick[div_b];

  // ------------------------------------------------------------
  // Scalers: down-counter plus halving toggle
  // ------------------------------------------------------------
  logic [7:0] scnt0_reg;
  logic [7:0] scnt1_reg;
  logic half0_reg;
  logic half1_reg;
  logic tick_s0;
  logic tick_s1;
  assign tick_s0 = tick_a && (scnt0_reg == pce_pkg::SCALE_ZERO) && half0_reg;
  assign tick_s1 = tick_b && (scnt1_reg == pce_pkg::SCALE_ZERO) && half1_reg;

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      scnt0_reg <= pce_pkg::RESET_BYTE;
      half0_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_scale0 && !load_block) begin
        scnt0_reg <= i_wdata;
      end else if (tick_a) begin
        if (scnt0_reg == pce_pkg::SCALE_ZERO) begin
          scnt0_reg <= scale_value_zero_reg;
          half0_reg <= ~half0_reg;
        end else begin
          scnt0_reg <= scnt0_reg - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      scnt1_reg <= pce_pkg::RESET_BYTE;
      half1_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_scale1 && !load_block) begin
        scnt1_reg <= i_wdata;
      end else if (tick_b) begin
        if (scnt1_reg == pce_pkg::SCALE_ZERO) begin
          scnt1_reg <= scale_value_one_reg;
          half1_reg <= ~half1_reg;
        end else begin
          scnt1_reg <= scnt1_reg - 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Per-channel clock select, gating and pin control
  // ------------------------------------------------------------
  logic [3:0] sel_tick;
  logic [3:0] eff_sel;
  logic [3:0] run_reg;
  logic [3:0] run_next;
  logic [3:0] pin_active;
  // Joined pair counts on the low-byte channel's clock (ch1 or ch3)
  assign eff_sel[0] = clock_select_and_polarity_reg[pce_pkg::FLD_SEL_LO + (
    clock_prescale_and_join_reg[pce_pkg::BIT_JOIN_LOWER] ? 1 : 0)];
  assign eff_sel[1] = clock_select_and_polarity_reg[pce_pkg::FLD_SEL_LO + 1];
  assign eff_sel[2] = clock_select_and_polarity_reg[pce_pkg::FLD_SEL_LO + (
    clock_prescale_and_join_reg[pce_pkg::BIT_JOIN_UPPER] ? 3 : 2)];
  assign eff_sel[3] = clock_select_and_polarity_reg[pce_pkg::FLD_SEL_LO + 3];
  assign pin_active[0] = channel_enable_reg[0];
  assign pin_active[1] = channel_enable_reg[1] &&
    !clock_prescale_and_join_reg[pce_pkg::BIT_JOIN_LOWER];
  assign pin_active[2] = channel_enable_reg[2];
  assign pin_active[3] = channel_enable_reg[3] &&
    !clock_prescale_and_join_reg[pce_pkg::BIT_JOIN_UPPER];

  genvar gc;
  generate
    for (gc = 0; gc < pce_pkg::CHANNELS; gc++) begin : g_chan
      if (gc < 2) begin : g_lo
        assign sel_tick[gc] = eff_sel[gc] ? tick_s0 : tick_a;
      end else begin : g_hi
        assign sel_tick[gc] = eff_sel[gc] ? tick_s1 : tick_b;
      end
      // Enabling tick counts, so the channel starts on that source edge
      assign run_next[gc] = channel_enable_reg[gc] &&
                            (run_reg[gc] || sel_tick[gc]);

      // Run flag rises only on a source tick and drops as soon as enable clears, so no partial clock gets out
      always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
          run_reg[gc] <= 1'b0;
        end else if (i_ce) begin
          if (!channel_enable_reg[gc]) begin
            run_reg[gc] <= 1'b0;
          end else if (sel_tick[gc]) begin
            run_reg[gc] <= 1'b1;
          end
        end
      end

      always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
          o_channel_tick[gc] <= 1'b0;
          o_pin_oe[gc] <= 1'b0;
          o_pin_data[gc] <= 1'b0;
          o_pwm_owns_pin[gc] <= 1'b0;
        end else if (i_ce) begin
          o_channel_tick[gc] <= run_next[gc] && sel_tick[gc];
          o_pwm_owns_pin[gc] <= pin_active[gc];
          o_pin_oe[gc] <= pin_active[gc] || i_port_direction_bits[gc];
          // Wave shows only once the run flag is up
          o_pin_data[gc] <= pin_active[gc] && run_reg[gc] &&
                            i_channel_wave[gc];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Mode outputs to the channel counters
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      o_channel_run <= 4'h0;
      o_output_polarity <= 4'h0;
      o_join_upper_pair <= 1'b0;
      o_join_lower_pair <= 1'b0;
      o_center_align_select <= 1'b0;
    end else if (i_ce) begin
      o_channel_run <= run_next;
      // Counter polarity: 0 starts low, duty counts low time
      o_output_polarity <= center_align_reg ? 4'h0 :
        clock_select_and_polarity_reg[3:0];
      o_join_upper_pair <=
        clock_prescale_and_join_reg[pce_pkg::BIT_JOIN_UPPER];
      o_join_lower_pair <=
        clock_prescale_and_join_reg[pce_pkg::BIT_JOIN_LOWER];
      o_center_align_select <= center_align_reg;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge rstn) begin
    if (!rstn) begin
      o_rdata <= pce_pkg::READ_IDLE;
    end else if (i_ce) begin
      if (!i_rd) begin
        o_rdata <= pce_pkg::READ_IDLE;
      end else if (i_addr == pce_pkg::ADDR_CLOCK_PRESCALE_AND_JOIN) begin
        o_rdata <= clock_prescale_and_join_reg;
      end else if (i_addr == pce_pkg::ADDR_CLOCK_SELECT_AND_POLARITY) begin
        o_rdata <= clock_select_and_polarity_reg;
      end else if (i_addr == pce_pkg::ADDR_CHANNEL_ENABLE) begin
        o_rdata <= {4'h0, channel_enable_reg};
      end else if (i_addr == pce_pkg::ADDR_PRESCALE_COUNTER) begin
        o_rdata <= {1'b0, prescale_reg};
      end else if (i_addr == pce_pkg::ADDR_SCALE_VALUE_ZERO) begin
        o_rdata <= scale_value_zero_reg;
      end else if (i_addr == pce_pkg::ADDR_SCALE_COUNTER_ZERO) begin
        o_rdata <= scnt0_reg;
      end else if (i_addr == pce_pkg::ADDR_SCALE_VALUE_ONE) begin
        o_rdata <= scale_value_one_reg;
      end else if (i_addr == pce_pkg::ADDR_SCALE_COUNTER_ONE) begin
        o_rdata <= scnt1_reg;
      end else if (i_addr == pce_pkg::ADDR_SPECIAL_CONTROL) begin
        o_rdata <= {2'b00, scaler_load_disable_reg, 1'b0, center_align_reg,
                    3'b000};
      end else begin
        o_rdata <= pce_pkg::READ_IDLE;
      end
    end
  end

endmodule : pce_clock_enable
`default_nettype wire

// File: design/pce_pkg.sv
// Package: register map, field layout and constants of the clock/enable block
package pce_pkg;
  localparam logic [7:0] ADDR_CLOCK_PRESCALE_AND_JOIN = 8'h40;
  localparam logic [7:0] ADDR_CLOCK_SELECT_AND_POLARITY = 8'h41;
  localparam logic [7:0] ADDR_CHANNEL_ENABLE = 8'h42;
  localparam logic [7:0] ADDR_PRESCALE_COUNTER = 8'h43;
  localparam logic [7:0] ADDR_SCALE_VALUE_ZERO = 8'h44;
  localparam logic [7:0] ADDR_SCALE_COUNTER_ZERO = 8'h45;
  localparam logic [7:0] ADDR_SCALE_VALUE_ONE = 8'h46;
  localparam logic [7:0] ADDR_SCALE_COUNTER_ONE = 8'h47;
  localparam logic [7:0] ADDR_SPECIAL_CONTROL = 8'h55;
  localparam int BIT_JOIN_UPPER = 7;
  localparam int BIT_JOIN_LOWER = 6;
  localparam int FLD_CLK_A_HI = 5;
  localparam int FLD_CLK_A_LO = 3;
  localparam int FLD_CLK_B_HI = 2;
  localparam int FLD_CLK_B_LO = 0;
  localparam int FLD_SEL_LO = 4;
  localparam int BIT_CENTER_ALIGN = 3;
  localparam int BIT_SCALER_LOAD_DISABLE = 5;
  localparam int CHANNELS = 4;
  localparam int PRESCALE_BITS = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] SCALE_ZERO = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
endpackage : pce_pkg

// File: verification/pce_clock_enable_properties.sv
// Port checker for the clock and enable front end
`timescale 1ns/100ps
`default_nettype none
module pce_clock_enable_properties (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [3:0] i_port_direction_bits,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] o_channel_tick,
  input wire logic [3:0] o_channel_run,
  input wire logic [3:0] o_output_polarity,
  input wire logic [3:0] o_pin_oe,
  input wire logic [3:0] o_pwm_owns_pin,
  input wire logic o_join_upper_pair,
  input wire logic o_join_lower_pair,
  input wire logic o_center_align_select
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_rdata_idle;
    i_ce && $past(i_ce) && !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  property p_prescale_msb;
    i_ce && i_rd && i_addr == pce_pkg::ADDR_PRESCALE_COUNTER |=> !o_rdata[7];
  endproperty
  property p_join_upper;
    o_join_upper_pair |-> !o_pwm_owns_pin[3];
  endproperty
  property p_join_lower;
    o_join_lower_pair |-> !o_pwm_owns_pin[1];
  endproperty
  property p_owner_drives;
    (o_pwm_owns_pin & ~o_pin_oe) == 4'h0;
  endproperty
  // Direction bits rule the pin only where the channel does not own it
  property p_dir_rules;
    i_ce && $past(i_ce) |->
      o_pin_oe == (o_pwm_owns_pin | $past(i_port_direction_bits));
  endproperty
  property p_tick_needs_run;
    (o_channel_tick & ~o_channel_run) == 4'h0;
  endproperty
  property p_first_tick;
    ((o_channel_run & ~$past(o_channel_run)) & ~o_channel_tick) == 4'h0;
  endproperty
  property p_center_pol;
    o_center_align_select |-> o_output_polarity == 4'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read cycle");
  a_prescale_msb: assert property (p_prescale_msb)
    else $error("prescaler read has bit 7 set");
  a_join_upper: assert property (p_join_upper)
    else $error("channel 3 pin owned while upper pair joined");
  a_join_lower: assert property (p_join_lower)
    else $error("channel 1 pin owned while lower pair joined");
  a_owner_drives: assert property (p_owner_drives)
    else $error("owned pin not driven as output");
  a_dir_rules: assert property (p_dir_rules)
    else $error("pin direction does not follow owner or direction bit");
  a_tick_needs_run: assert property (p_tick_needs_run)
    else $error("tick on a channel that is not running");
  a_first_tick: assert property (p_first_tick)
    else $error("channel started without a clock tick");
  a_center_pol: assert property (p_center_pol)
    else $error("polarity active in center-aligned mode");
  c_join: cover property (o_join_upper_pair && o_join_lower_pair);
  c_center: cover property (o_center_align_select);
  c_all_run: cover property (o_channel_run == 4'hf);
endmodule : pce_clock_enable_properties
`default_nettype wire

// File: verification/pce_clock_enable_tb_top.sv
// Self-checking bench of the clock and enable front end
`timescale 1ns/100ps
`default_nettype none
module pce_clock_enable_tb_top;
  localparam logic [7:0] A_PJ = pce_pkg::ADDR_CLOCK_PRESCALE_AND_JOIN;
  localparam logic [7:0] A_POL = pce_pkg::ADDR_CLOCK_SELECT_AND_POLARITY;
  localparam logic [7:0] A_EN = pce_pkg::ADDR_CHANNEL_ENABLE;
  localparam logic [7:0] A_PRE = pce_pkg::ADDR_PRESCALE_COUNTER;
  localparam logic [7:0] A_SV0 = pce_pkg::ADDR_SCALE_VALUE_ZERO;
  localparam logic [7:0] A_SC0 = pce_pkg::ADDR_SCALE_COUNTER_ZERO;
  localparam logic [7:0] A_SP = pce_pkg::ADDR_SPECIAL_CONTROL;
  logic clk, rstn, ce, wr, rd, smode, jup, jlo, cen;
  logic [7:0] addr, wdata, rdata, v, w, e, p1, p2;
  logic [3:0] dir, wave, tick, run, pol, pdata, oe, owns;
  logic [7:0] exp_q[$];
  string name_q[$];
  logic rd_seen = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  int c0, c2;
  pce_clock_enable i_pce_clock_enable (.i_core_clk(clk), .i_rstn(rstn),
    .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .i_special_mode_flag(smode), .i_port_direction_bits(dir),
    .i_channel_wave(wave), .o_rdata(rdata), .o_channel_tick(tick),
    .o_channel_run(run), .o_output_polarity(pol), .o_pin_data(pdata),
    .o_pin_oe(oe), .o_pwm_owns_pin(owns), .o_join_upper_pair(jup),
    .o_join_lower_pair(jlo), .o_center_align_select(cen));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] seen,
                     input logic [7:0] ex);
    num_checks++;
    if (seen !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, ex, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] ex,
                        input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(ex);
    name_q.push_back(n);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // Extra edge at the end keeps the monitor off an empty queue race
  task automatic rd_cap(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask : rd_cap
  task automatic count_ticks(input int n);
    c0 = 0;
    c2 = 0;
    repeat (n) begin
      @(posedge clk);
      if (tick[0] === 1'b1) c0++;
      if (tick[2] === 1'b1) c2++;
    end
  endtask : count_ticks
  task give_verdict;
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(name_q.pop_front(), rdata, exp_q.pop_front());
    end
    rd_seen <= rd && ce;
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("Watchdog expired");
    give_verdict();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {ce, wr, rd, smode, rstn} = 5'b10000;
    {addr, wdata, dir, wave} = '0;
    void'($urandom(32'hd78b2e88));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(A_PJ, 8'h00, "join reset");
    rd_reg(A_POL, 8'h00, "polarity reset");
    rd_reg(A_EN, 8'h00, "enable reset");
    rd_reg(A_SC0, 8'h00, "scale counter reset");
    rd_reg(8'h50, 8'h00, "unmapped");
    $display("Test reset values done");
    // Slowest clock A keeps the stopped prescaler from ticking
    wr_reg(A_PJ, 8'h38);
    v = 8'($urandom);
    wr_reg(A_SV0, v);
    rd_reg(A_SC0, v, "scale load");
    wr_reg(A_PRE, 8'h55);
    rd_reg(A_PRE, 8'h00, "prescaler normal write");
    smode <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(A_SP, 8'h20);
    w = 8'($urandom);
    wr_reg(A_SV0, w);
    rd_reg(A_SC0, v, "load disabled");
    rd_reg(A_SV0, w, "scale value");
    e = 8'($urandom) & 8'h7f;
    wr_reg(A_PRE, e);
    rd_reg(A_PRE, e, "prescaler special write");
    wr_reg(A_SP, 8'h00);
    smode <= 1'b0;
    $display("Test scale and prescaler done");
    wr_reg(A_PJ, 8'h00);
    wr_reg(A_EN, 8'h01);
    rd_cap(A_PRE, p1);
    rd_cap(A_PRE, p2);
    chk("prescaler runs", p2, (p1 + 8'h03) & 8'h7f);
    v = 8'($urandom) & 8'h0f;
    e = 8'($urandom) & 8'h0f;
    dir <= 4'($urandom);
    wave <= 4'($urandom);
    wr_reg(A_POL, v);
    wr_reg(A_EN, e);
    repeat (4) @(posedge clk);
    chk("owns", 8'(owns), e);
    chk("oe", 8'(oe), e | 8'(dir));
    chk("run", 8'(run), e);
    chk("tick", 8'(tick), e);
    chk("pin data", 8'(pdata), e & 8'(wave));
    chk("polarity", 8'(pol), v);
    wr_reg(A_PJ, 8'hc0);
    repeat (3) @(posedge clk);
    chk("joined owns", 8'(owns), e & 8'h05);
    chk("joined pin", 8'(pdata), e & 8'(wave) & 8'h05);
    chk("join bits", {6'h0, jup, jlo}, 8'h03);
    wr_reg(A_SP, 8'h08);
    repeat (3) @(posedge clk);
    chk("center polarity", {3'h0, cen, pol}, 8'h10);
    wr_reg(A_SP, 8'h00);
    repeat (3) @(posedge clk);
    chk("left polarity", 8'(pol), v);
    $display("Test pins and polarity done");
    wr_reg(A_POL, 8'h00);
    wr_reg(A_EN, 8'h05);
    for (int f = 0; f < 8; f++) begin
      wr_reg(A_PJ, {2'b00, 3'(f), 3'(f)});
      repeat (4) @(posedge clk);
      count_ticks(128);
      chk("clock A rate", 8'(c0), 8'(128 >> f));
      chk("clock B rate", 8'(c2), 8'(128 >> f));
    end
    $display("Test prescaler taps done");
    // Low clock enable must freeze the running prescaler
    rd_cap(A_PRE, p1);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    rd_cap(A_PRE, p2);
    chk("prescaler frozen", p2, (p1 + 8'h03) & 8'h7f);
    $display("Test clock enable done");
    wr_reg(A_PJ, 8'h00);
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom_range(7));
      // Clock selection only changes while the channels are stopped
      wr_reg(A_EN, 8'h00);
      wr_reg(A_SV0, v);
      wr_reg(pce_pkg::ADDR_SCALE_VALUE_ONE, v);
      wr_reg(A_POL, 8'h50);
      wr_reg(A_EN, 8'h05);
      repeat (4 * (v + 1)) @(posedge clk);
      count_ticks(16 * (v + 1));
      chk("scaled zero rate", 8'(c0), 8'h08);
      chk("scaled one rate", 8'(c2), 8'h08);
    end
    $display("Test scaled clocks done");
    wr_reg(A_EN, 8'h00);
    repeat (3) @(posedge clk);
    chk("all stopped", 8'(run), 8'h00);
    rd_cap(A_PRE, p1);
    rd_cap(A_PRE, p2);
    chk("prescaler halted", p2, p1);
    $display("Test shutdown done");
    give_verdict();
  end
endmodule : pce_clock_enable_tb_top
bind pce_clock_enable pce_clock_enable_properties i_chk (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
  .i_rd(i_rd), .i_port_direction_bits(i_port_direction_bits),
  .o_rdata(o_rdata), .o_channel_tick(o_channel_tick),
  .o_channel_run(o_channel_run), .o_output_polarity(o_output_polarity),
  .o_pin_oe(o_pin_oe), .o_pwm_owns_pin(o_pwm_owns_pin),
  .o_join_upper_pair(o_join_upper_pair),
  .o_join_lower_pair(o_join_lower_pair),
  .o_center_align_select(o_center_align_select));
`default_nettype wire
